// >>> src/flic_map.vh
// Register map, field positions and reset values of the interrupt controller
`ifndef FLIC_MAP_VH
`define FLIC_MAP_VH
// Register byte addresses on the AXI4-Lite bus
`define FLIC_EN_LOW_ADDR 8'ha8
`define FLIC_EN_HIGH_ADDR 8'hb1
`define FLIC_PRIO_LOW_ADDR 8'hb8
`define FLIC_PRIO_HIGH_ADDR 8'hb4
`define FLIC_SELECT_ADDR 8'hc0
`define FLIC_TIMER_CTRL_ADDR 8'h88
`define FLIC_KEYPAD_EN_ADDR 8'h9c
`define FLIC_STATUS_ADDR 8'hc4
// Enable-low register fields
`define FLIC_GLOBAL_EN_BIT 7
`define FLIC_EN_LOW_RESET 8'h00
`define FLIC_EN_LOW_MASK 8'h9f
// Enable-high register fields
`define FLIC_USB_EN_BIT 6
`define FLIC_CARD_EN_BIT 3
`define FLIC_SPI_EN_BIT 2
`define FLIC_KEYPAD_EN_BIT 0
`define FLIC_EN_HIGH_RESET 8'h00
`define FLIC_EN_HIGH_MASK 8'h4d
// Selection register fields
`define FLIC_SEL_RX_EN_BIT 0
`define FLIC_SEL_CARD_EN_BIT 1
`define FLIC_SEL_PIN_LEVEL_BIT 2
`define FLIC_SEL_PIN_EN_BIT 3
`define FLIC_SEL_RX_FLAG_BIT 4
`define FLIC_SEL_CARD_FLAG_BIT 5
`define FLIC_SEL_CARD_LEVEL_BIT 7
`define FLIC_SEL_RESET 8'h00
// Timer control fields
`define FLIC_TIMER_CONTROL_REG_TRIG_BIT 2
`define FLIC_TIMER_CONTROL_REG_FLAG_BIT 3
`define FLIC_TIMER_CONTROL_REG_RESET 8'h00
// Source indices in polling order; index 0 is polled first
`define FLIC_NSRC 15
`define FLIC_SRC_EXT0 0
`define FLIC_SRC_TIMER0 1
`define FLIC_SRC_EXT1 2
`define FLIC_SRC_TIMER1 3
`define FLIC_SRC_SERIAL 4
`define FLIC_SRC_SPI 5
`define FLIC_SRC_KEYPAD 6
`define FLIC_SRC_USB 7
`define FLIC_SRC_CARD 8
`define FLIC_NO_SRC 4'hf
// AXI response codes
`define FLIC_RESP_OKAY 2'b00
`define FLIC_RESP_SLVERR 2'b10
`endif

// >>> src/flic_top.v
// Four-level interrupt controller with AXI4-Lite register slave
//
// Behaviour
// - Fifteen request slots, nine sources wired
// - Per-source enable gates each request
// - Global enable bit 7 blocks everything
// - Two priority bits form levels zero to three
// - Preempt only by strictly higher level
// - Level three service is never preempted
// - Higher level pending request wins
// - Same level resolved by fixed polling order
// - Ext1 vector shared by pin, rx, card
// - Ext1 pin needs its pin enable
// - Ext1 pin level or falling edge
// - Level mode active polarity is selectable
// - Ext1 flag set by pin, cleared on service
// - Rx flag set on low rx level
// - Card needs select bit1, ext1, global
// - Card detection level from select bit 7
// - Card flag sticky, software clears it
// - Enable-low layout and zero reset
// - Enable-high layout for usb, card, spi, keypad
// - Reserved enable bits ignore writes, read zero
// - Keypad line flag needs its line enable
`timescale 1ns/10ps
`include "flic_map.vh"
module flic_top (
   input wire CLK,
   input wire RESET,
   // AXI4-Lite slave
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Interrupt sources
   input wire EXT0_PIN,
   input wire EXT1_PIN,
   input wire RX_LINE,
   input wire CARD_PRESENCE_INPUT,
   input wire TIMER0_OVF,
   input wire TIMER1_OVF,
   input wire SERIAL_REQ,
   input wire SPI_REQ,
   input wire USB_REQ,
   input wire CARD_IF_REQ,
   input wire [7:0] KEYPAD_FLAG_REG,
   input wire [7:0] KEYPAD_LINE_ENABLE_REG,
   input wire [5:0] UNUSED_REQ,
   // Core side
   output reg IRQ_VALID,
   output reg [3:0] IRQ_SOURCE,
   output reg [1:0] IRQ_LEVEL,
   input wire IRQ_ACK,
   input wire IRQ_RETURN
);

   // Software-visible registers
   reg [7:0] en_low_ff;
   reg [7:0] en_high_ff;
   reg [7:0] prio_low_ff;
   reg [7:0] prio_high_ff;
   reg [7:0] sel_ff;
   reg [7:0] timer_control_reg_ff;
   reg ext1_pin_d_ff;
   // Nesting stack: one bit per level in service
   reg [3:0] active_ff;
   // Bus slave state
   reg aw_hold_ff;
   reg w_hold_ff;
   reg [7:0] aw_addr_ff;
   reg [7:0] w_data_ff;
   reg w_strb_ff;

   // Priority bits follow the enable layout for the five older sources;
   // the newer spi, keypad and usb sources take the spare positions 5 to 7, and the card
   // interface shares the serial port bit. Moving this mapping would
   // shift levels under running software, so it stays fixed.
   // Level of a source from its two priority bits
   function [1:0] src_level;
      input [3:0] idx;
      input [7:0] hi;
      input [7:0] lo;
      reg [2:0] b;
      begin
         b = 3'd0;
         case (idx)
            `FLIC_SRC_SPI: b = 3'd5;
            `FLIC_SRC_KEYPAD: b = 3'd6;
            `FLIC_SRC_USB: b = 3'd7;
            `FLIC_SRC_CARD: b = 3'd4;
            default: b = idx[2:0];
         endcase
         src_level = {hi[b], lo[b]};
      end
   endfunction

   // The stack keeps one bit per level, so nesting is bounded by the
   // four levels; a second entry at an occupied level cannot happen
   // because the arbiter only offers strictly higher levels.
   // Highest level currently in service, or -1 when idle
   function [2:0] top_level;
      input [3:0] act;
      begin
         if (act[3])
            top_level = 3'd3;
         else if (act[2])
            top_level = 3'd2;
         else if (act[1])
            top_level = 3'd1;
         else if (act[0])
            top_level = 3'd0;
         else
            top_level = 3'd7;
      end
   endfunction

   // Hazard: the falling-edge detector compares with the previous pin
   // sample, which resets to the idle high level, so leaving reset
   // with the pin low looks like a falling edge.
   // Limitation: a pulse shorter than one clock can be missed, since
   // the pins are taken as synchronous and sampled once per edge.
   // Pin and shared-vector conditions for ext1
   wire global_irq_enable = en_low_ff[`FLIC_GLOBAL_EN_BIT];
   wire ext1_irq_enable = en_low_ff[2];
   wire ext1_trigger_type = timer_control_reg_ff[`FLIC_TIMER_CONTROL_REG_TRIG_BIT];
   wire ext1_pin_level_select = sel_ff[`FLIC_SEL_PIN_LEVEL_BIT];
   wire ext1_pin_enable = sel_ff[`FLIC_SEL_PIN_EN_BIT];
   wire card_presence_level_select = sel_ff[`FLIC_SEL_CARD_LEVEL_BIT];
   wire pin_level_hit = (EXT1_PIN == ext1_pin_level_select);
   wire pin_fall_hit = ext1_pin_d_ff & ~EXT1_PIN;
   wire pin_hit = ext1_pin_enable &
      (ext1_trigger_type ? pin_fall_hit : pin_level_hit);
   wire rx_hit = ~RX_LINE;
   wire card_hit = (CARD_PRESENCE_INPUT == card_presence_level_select);
   wire ext1_flag = timer_control_reg_ff[`FLIC_TIMER_CONTROL_REG_FLAG_BIT];
   wire rx_line_flag = sel_ff[`FLIC_SEL_RX_FLAG_BIT];
   wire card_presence_flag = sel_ff[`FLIC_SEL_CARD_FLAG_BIT];
   // Vector 2 merges the three ext1 inputs
   wire ext1_vec = ext1_flag |
      (rx_line_flag & sel_ff[`FLIC_SEL_RX_EN_BIT]) |
      (card_presence_flag & sel_ff[`FLIC_SEL_CARD_EN_BIT]);
   wire keypad_any = |(KEYPAD_FLAG_REG & KEYPAD_LINE_ENABLE_REG);

   // Unused slots ride in the vector only so that the slot count
   // matches the controller width; they never reach the arbiter.
   // Raw request slots; six slots stay unwired into the selector
   wire [`FLIC_NSRC-1:0] raw_req = {UNUSED_REQ,
      CARD_IF_REQ, USB_REQ, keypad_any, SPI_REQ, SERIAL_REQ,
      TIMER1_OVF, ext1_vec, TIMER0_OVF, EXT0_PIN == 1'b0};
   wire [8:0] src_en = {en_high_ff[`FLIC_CARD_EN_BIT],
      en_high_ff[`FLIC_USB_EN_BIT], en_high_ff[`FLIC_KEYPAD_EN_BIT],
      en_high_ff[`FLIC_SPI_EN_BIT], en_low_ff[4], en_low_ff[3],
      ext1_irq_enable, en_low_ff[1], en_low_ff[0]};
   // Request gating every cycle
   wire [8:0] gated_req = raw_req[8:0] & src_en &
      {9{global_irq_enable}};

   // The loop walks the slots in polling order and replaces the winner
   // only on a strictly higher level, so ties keep the earlier slot.
   // This costs a longer compare chain than a parallel tree, but the
   // source count is small and the order stays plain in the code.
   // Arbiter: best level, then lowest index (ext0 first)
   reg [3:0] win_idx;
   reg [1:0] win_lvl;
   reg win_any;
   integer i;
   always @* begin
      win_idx = `FLIC_NO_SRC;
      win_lvl = 2'd0;
      win_any = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
         if (gated_req[i] && (!win_any ||
            src_level(i[3:0], prio_high_ff, prio_low_ff) > win_lvl)) begin
            win_any = 1'b1;
            win_idx = i[3:0];
            win_lvl = src_level(i[3:0], prio_high_ff, prio_low_ff);
         end
      end
   end

   // Offer only above the level in service
   wire [2:0] cur_top = top_level(active_ff);
   wire can_preempt = win_any && (cur_top == 3'd7 ||
      (cur_top != 3'd3 && {1'b0, win_lvl} > cur_top));
   wire take = IRQ_ACK & IRQ_VALID;

   // The offer drops for one cycle after each acknowledge, which gives
   // the stack time to record the new level before the next compare.
   // Core-facing request registers
   always @(posedge CLK) begin
      if (RESET) begin
         IRQ_VALID <= 1'b0;
         IRQ_SOURCE <= `FLIC_NO_SRC;
         IRQ_LEVEL <= 2'd0;
      end else begin
         IRQ_VALID <= can_preempt & ~take;
         IRQ_SOURCE <= can_preempt ? win_idx : `FLIC_NO_SRC;
         IRQ_LEVEL <= win_lvl;
      end
   end

   // A return and an acknowledge in one cycle both apply: the pop acts
   // on the old top, then the push records the newly taken level.
   // Nesting stack: push on ack, pop the top on return
   reg [3:0] nxt_active;
   always @* begin
      nxt_active = active_ff;
      if (IRQ_RETURN && cur_top != 3'd7)
         nxt_active[cur_top[1:0]] = 1'b0;
      if (take)
         nxt_active[IRQ_LEVEL] = 1'b1;
   end
   always @(posedge CLK) begin
      if (RESET)
         active_ff <= 4'h0;
      else
         active_ff <= nxt_active;
   end

   // Only one write may be in flight; holding both ready outputs low
   // while a response waits stops a second write overtaking the first.
   // Byte lane 0 carries the whole register, other lanes are ignored.
   // AXI handshakes: take each channel once, answer once both have arrived, held or in this cycle
   assign S_AXI_AWREADY = ~aw_hold_ff & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_hold_ff & ~S_AXI_BVALID;
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   wire aw_now = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_now = S_AXI_WVALID & S_AXI_WREADY;
   wire have_aw = aw_hold_ff | aw_now;
   wire have_w = w_hold_ff | w_now;
   wire [7:0] wr_addr = aw_hold_ff ? aw_addr_ff : S_AXI_AWADDR;
   wire [7:0] wr_data = w_hold_ff ? w_data_ff : S_AXI_WDATA[7:0];
   wire wr_lane = w_hold_ff ? w_strb_ff : S_AXI_WSTRB[0];
   wire wr_go = have_aw & have_w;
   wire wr_map = (wr_addr == `FLIC_EN_LOW_ADDR) ||
      (wr_addr == `FLIC_EN_HIGH_ADDR) || (wr_addr == `FLIC_PRIO_LOW_ADDR) ||
      (wr_addr == `FLIC_PRIO_HIGH_ADDR) || (wr_addr == `FLIC_SELECT_ADDR) ||
      (wr_addr == `FLIC_TIMER_CTRL_ADDR);
   wire wr_en = wr_go & wr_lane & wr_map;

   always @(posedge CLK) begin
      if (RESET) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 8'h00;
         w_strb_ff <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `FLIC_RESP_OKAY;
      end else begin
         if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
         if (wr_go) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_map ? `FLIC_RESP_OKAY : `FLIC_RESP_SLVERR;
         end else begin
            if (aw_now) begin
               aw_hold_ff <= 1'b1;
               aw_addr_ff <= S_AXI_AWADDR;
            end
            if (w_now) begin
               w_hold_ff <= 1'b1;
               w_data_ff <= S_AXI_WDATA[7:0];
               w_strb_ff <= S_AXI_WSTRB[0];
            end
         end
      end
   end

   // Priority registers keep all eight bits; each position is used by at
   // least one source (bit 4 by serial and card), so none is reserved here.
   // Plain registers; reserved bits are not stored
   always @(posedge CLK) begin
      if (RESET) begin
         en_low_ff <= `FLIC_EN_LOW_RESET;
         en_high_ff <= `FLIC_EN_HIGH_RESET;
         prio_low_ff <= 8'h00;
         prio_high_ff <= 8'h00;
         ext1_pin_d_ff <= 1'b1;
      end else begin
         ext1_pin_d_ff <= EXT1_PIN;
         if (wr_en && wr_addr == `FLIC_EN_LOW_ADDR)
            en_low_ff <= wr_data & `FLIC_EN_LOW_MASK;
         if (wr_en && wr_addr == `FLIC_EN_HIGH_ADDR)
            en_high_ff <= wr_data & `FLIC_EN_HIGH_MASK;
         if (wr_en && wr_addr == `FLIC_PRIO_LOW_ADDR)
            prio_low_ff <= wr_data;
         if (wr_en && wr_addr == `FLIC_PRIO_HIGH_ADDR)
            prio_high_ff <= wr_data;
      end
   end

   // Rx and card flags are cleared only by software writing zero; the
   // ext1 flag is also cleared when its vector is acknowledged.
   // Flags: hardware set wins over any clear in the same cycle
   wire ext1_serviced = take && IRQ_SOURCE == `FLIC_SRC_EXT1;
   wire sel_wr = wr_en && wr_addr == `FLIC_SELECT_ADDR;
   wire timer_control_reg_wr = wr_en && wr_addr == `FLIC_TIMER_CTRL_ADDR;
   reg [7:0] nxt_sel;
   reg [7:0] nxt_timer_control_reg;
   always @* begin
      nxt_sel = sel_wr ? wr_data : sel_ff;
      nxt_sel[6] = 1'b0;
      nxt_timer_control_reg = timer_control_reg_wr ? wr_data : timer_control_reg_ff;
      if (ext1_serviced)
         nxt_timer_control_reg[`FLIC_TIMER_CONTROL_REG_FLAG_BIT] = 1'b0;
      if (pin_hit)
         nxt_timer_control_reg[`FLIC_TIMER_CONTROL_REG_FLAG_BIT] = 1'b1;
      if (rx_hit)
         nxt_sel[`FLIC_SEL_RX_FLAG_BIT] = 1'b1;
      if (card_hit)
         nxt_sel[`FLIC_SEL_CARD_FLAG_BIT] = 1'b1;
   end
   always @(posedge CLK) begin
      if (RESET) begin
         sel_ff <= `FLIC_SEL_RESET;
         timer_control_reg_ff <= `FLIC_TIMER_CONTROL_REG_RESET;
      end else begin
         sel_ff <= nxt_sel;
         timer_control_reg_ff <= nxt_timer_control_reg;
      end
   end

   // Read data are taken while the address is offered, so the value
   // returned is the register contents at the accepting edge.
   // Read channel: one cycle to answer, held until taken
   reg [7:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         `FLIC_EN_LOW_ADDR: rd_val = en_low_ff;
         `FLIC_EN_HIGH_ADDR: rd_val = en_high_ff;
         `FLIC_PRIO_LOW_ADDR: rd_val = prio_low_ff;
         `FLIC_PRIO_HIGH_ADDR: rd_val = prio_high_ff;
         `FLIC_SELECT_ADDR: rd_val = sel_ff;
         `FLIC_TIMER_CTRL_ADDR: rd_val = timer_control_reg_ff;
         `FLIC_STATUS_ADDR: rd_val = {active_ff, IRQ_SOURCE};
         default: begin
            rd_val = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end
   always @(posedge CLK) begin
      if (RESET) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `FLIC_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= {24'h000000, rd_val};
         S_AXI_RRESP <= rd_ok ? `FLIC_RESP_OKAY : `FLIC_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule // flic_top

// >>> tb/flic_props.sv
// Port-level checker for the interrupt controller
`timescale 1ns/10ps
`include "flic_map.vh"
module flic_props (
   input wire CLK,
   input wire RESET,
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire IRQ_VALID,
   input wire [3:0] IRQ_SOURCE,
   input wire [1:0] IRQ_LEVEL,
   input wire IRQ_ACK,
   input wire IRQ_RETURN
);
   reg ge_ff;
   reg [3:0] act_ff;
   wire wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY;
   wire [1:0] top = act_ff[3] ? 2'h3 : act_ff[2] ? 2'h2 : {1'b0, act_ff[1]};
   // Mirror global enable and the set of levels in service
   always @(posedge CLK) begin
      if (RESET) begin
         ge_ff <= 1'b0;
         act_ff <= 4'h0;
      end else begin
         if (wr_take && S_AXI_AWADDR == `FLIC_EN_LOW_ADDR && S_AXI_WSTRB[0])
            ge_ff <= S_AXI_WDATA[7];
         if (IRQ_VALID && IRQ_ACK)
            act_ff[IRQ_LEVEL] <= 1'b1;
         else if (IRQ_RETURN && act_ff != 4'h0)
            act_ff[top] <= 1'b0;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence wr_seq; wr_take; endsequence
   sequence rd_seq; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
   reset_idle_a: assert property ($fell(RESET) |-> !IRQ_VALID
      && IRQ_SOURCE == `FLIC_NO_SRC) else $error("offer after reset");
   valid_src_a: assert property (IRQ_VALID |-> IRQ_SOURCE < 4'h9)
      else $error("offer from unwired slot");
   global_gate_a: assert property (!ge_ff && !$past(ge_ff)
      && !$past(ge_ff, 2) |-> !IRQ_VALID) else $error("global off leak");
   preempt_higher_a: assert property (IRQ_VALID && act_ff != 4'h0
      |-> IRQ_LEVEL > top) else $error("offer not above active level");
   write_answer_a: assert property (wr_seq |=> S_AXI_BVALID)
      else $error("no write response");
   read_answer_a: assert property (rd_seq |=> S_AXI_RVALID)
      else $error("no read data");
   bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID) else $error("write response dropped");
   rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID) else $error("read data dropped");
   ar_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while answer pending");
endmodule // flic_props

// >>> tb/flic_core_model.sv
// Behavioural processor core that takes and retires interrupts
`timescale 1ns/10ps
module flic_core_model (
   input wire clk,
   input wire rst,
   input wire valid,
   input wire [3:0] lat,
   input wire hold,
   output reg ack = 1'b0,
   output reg ret = 1'b0
);
   int wait_cnt;
   int depth;
   // Take an offer after lat cycles; retire one service at most every other open hold cycle
   always @(posedge clk) begin
      ack <= 1'b0;
      ret <= 1'b0;
      if (rst) begin
         wait_cnt = 0;
         depth = 0;
      end else if (valid && !ack) begin
         if (wait_cnt >= lat) begin
            ack <= 1'b1;
            depth++;
            wait_cnt = 0;
         end else
            wait_cnt++;
      end else if (!hold && depth > 0 && !ret) begin
         ret <= 1'b1; // Return only after its acknowledge
         depth--;
      end
   end
endmodule // flic_core_model

// >>> tb/flic_top_test.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "flic_map.vh"
module flic_top_test;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic rxl = 1, hold = 1, e1 = 1, cp = 1;
   logic [7:0] awaddr = 0, araddr = 0, kf = 0, ke = 0, f, e;
   logic [7:0] req = 0; // Ext0, t0, t1, serial, spi, usb, card if
   logic [31:0] wdata = 0;
   logic [3:0] lat = 0;
   logic [3:0] st [0:6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};
   wire awrdy, wrdy, bvalid, arrdy, rvalid, irq_v, ack, ret;
   wire [1:0] bresp, rresp, irq_l;
   wire [31:0] rdata;
   wire [3:0] irq_s;
   int error_cnt = 0, checks_done = 0;
   logic [33:0] rexp [$];
   logic [5:0] iexp [$];
   always #10 clk = ~clk;
   flic_top dut_u (.CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .EXT0_PIN(~req[0]), .EXT1_PIN(e1),
      .RX_LINE(rxl), .CARD_PRESENCE_INPUT(cp), .TIMER0_OVF(req[1]),
      .TIMER1_OVF(req[2]), .SERIAL_REQ(req[3]), .SPI_REQ(req[4]),
      .USB_REQ(req[5]), .CARD_IF_REQ(req[6]), .KEYPAD_FLAG_REG(kf),
      .KEYPAD_LINE_ENABLE_REG(ke), .UNUSED_REQ(6'h00), .IRQ_VALID(irq_v),
      .IRQ_SOURCE(irq_s), .IRQ_LEVEL(irq_l), .IRQ_ACK(ack), .IRQ_RETURN(ret));
   flic_core_model core_u (.clk(clk), .rst(rst), .valid(irq_v), .lat(lat),
      .hold(hold), .ack(ack), .ret(ret));
   task check(input logic [33:0] s, input logic [33:0] x, input string m);
      checks_done++;
      if (s !== x) begin
         error_cnt++;
         $display("MISMATCH %0t %s seen %h want %h", $time, m, s, x);
      end
   endtask
   task print_verdict;
      $display("Mismatches %0d, checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Write address and data go out together, each released when taken
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awv && awrdy) awv <= 0;
         if (wv && wrdy) wv <= 0;
      end while (!bvalid);
      bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [33:0] x);
      @(posedge clk);
      rexp.push_back(x);
      araddr <= a;
      arv <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         if (arv && arrdy) arv <= 0;
      end while (!rvalid);
      rready <= 0;
   endtask
   // Wait until at most k offers are still expected
   task drain(input int k);
      int n;
      n = 0;
      while (iexp.size() > k && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n == 300) check(34'h1, 34'h0, "offer missing");
   endtask
   task quiet(input int c);
      repeat (c) begin
         @(posedge clk);
         check({33'h0, irq_v}, 34'h0, "unwanted offer");
      end
   endtask
   // One retirement from the core, then settle
   task pop1;
      hold <= 0;
      @(posedge clk);
      hold <= 1;
      repeat (2) @(posedge clk);
   endtask
   // Monitors take the oldest note whenever a result shows
   always @(posedge clk) if (rvalid && rready)
      check({rresp, rdata}, rexp.size() ? rexp.pop_front() : 34'bx, "read");
   always @(posedge clk) if (irq_v && ack)
      check({28'h0, irq_s, irq_l},
         {28'h0, iexp.size() ? iexp.pop_front() : 6'bx}, "offer");
   initial begin
      #400000;
      error_cnt++;
      print_verdict;
   end
   initial begin
      lat = 4'($urandom(63) % 8);
      repeat (20) @(posedge clk);
      rst <= 0;
      rd(`FLIC_EN_LOW_ADDR, {`FLIC_RESP_OKAY, 32'h0});
      rd(`FLIC_EN_HIGH_ADDR, {`FLIC_RESP_OKAY, 32'h0});
      wr(`FLIC_EN_LOW_ADDR, 8'h9f);
      rd(`FLIC_EN_LOW_ADDR, {`FLIC_RESP_OKAY, 32'h9f});
      wr(`FLIC_EN_HIGH_ADDR, 8'h4d);
      rd(`FLIC_EN_HIGH_ADDR, {`FLIC_RESP_OKAY, 32'h4d});
      rd(8'h10, {`FLIC_RESP_SLVERR, 32'h0});
      wr(`FLIC_EN_LOW_ADDR, 8'h1f);
      req <= 8'h7f;
      kf <= 8'hff;
      ke <= 8'hff;
      quiet(6);
      req <= 0;
      kf <= 0;
      wr(`FLIC_EN_LOW_ADDR, 8'h9f);
      // Every wired plain source in turn, random core latency
      for (int i = 0; i < 7; i++) begin
         lat <= 4'($urandom % 8);
         iexp.push_back({st[i], 2'b00});
         req <= 8'h01 << i;
         drain(0);
         req <= 0;
         pop1;
      end
      wr(`FLIC_PRIO_LOW_ADDR, 8'h02);
      iexp.push_back({4'h1, 2'b01});
      iexp.push_back({4'h0, 2'b00});
      req <= 8'h03;
      drain(1);
      req <= 8'h01;
      pop1;
      drain(0);
      req <= 0;
      pop1;
      wr(`FLIC_PRIO_LOW_ADDR, 8'h00);
      iexp.push_back({4'h3, 2'b00});
      req <= 8'h0c;
      drain(0);
      quiet(4);
      iexp.push_back({4'h4, 2'b10});
      wr(`FLIC_PRIO_HIGH_ADDR, 8'h90);
      drain(0);
      iexp.push_back({4'h4, 2'b11});
      wr(`FLIC_PRIO_LOW_ADDR, 8'h90);
      drain(0);
      req <= 8'h20;
      quiet(4);
      req <= 0;
      repeat (3) pop1;
      // Keypad lines count only where their enable is set
      repeat (4) begin
         f = 8'($urandom);
         e = 8'($urandom);
         kf <= f;
         ke <= e;
         if (|(f & e)) begin
            iexp.push_back({4'h6, 2'b00});
            drain(0);
         end else
            quiet(4);
         kf <= 0;
         pop1;
      end
      wr(`FLIC_SELECT_ADDR, 8'h01);
      iexp.push_back({4'h2, 2'b00});
      rxl <= 0;
      @(posedge clk);
      rxl <= 1;
      drain(0);
      rd(`FLIC_SELECT_ADDR, {`FLIC_RESP_OKAY, 32'h11});
      wr(`FLIC_SELECT_ADDR, 8'h00);
      pop1;
      rd(`FLIC_SELECT_ADDR, {`FLIC_RESP_OKAY, 32'h00});
      // Card presence shares the ext1 vector; its flag stays until cleared
      wr(`FLIC_SELECT_ADDR, 8'h02);
      iexp.push_back({4'h2, 2'b00});
      cp <= 0;
      @(posedge clk);
      cp <= 1;
      drain(0);
      rd(`FLIC_SELECT_ADDR, {`FLIC_RESP_OKAY, 32'h22});
      wr(`FLIC_SELECT_ADDR, 8'h00);
      pop1;
      rd(`FLIC_SELECT_ADDR, {`FLIC_RESP_OKAY, 32'h00});
      // Ext1 pin on a falling edge, then on a high level
      wr(`FLIC_TIMER_CTRL_ADDR, 8'h04);
      wr(`FLIC_SELECT_ADDR, 8'h08);
      iexp.push_back({4'h2, 2'b00});
      e1 <= 0;
      drain(0);
      rd(`FLIC_TIMER_CTRL_ADDR, {`FLIC_RESP_OKAY, 32'h04});
      pop1;
      e1 <= 1;
      wr(`FLIC_SELECT_ADDR, 8'h0c);
      iexp.push_back({4'h2, 2'b00});
      wr(`FLIC_TIMER_CTRL_ADDR, 8'h00);
      drain(0);
      rd(`FLIC_TIMER_CTRL_ADDR, {`FLIC_RESP_OKAY, 32'h08});
      wr(`FLIC_SELECT_ADDR, 8'h04);
      wr(`FLIC_TIMER_CTRL_ADDR, 8'h00);
      pop1;
      quiet(4);
      print_verdict;
   end
endmodule // flic_top_test
bind flic_top flic_props props_u (.CLK(CLK), .RESET(RESET),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .IRQ_VALID(IRQ_VALID),
   .IRQ_SOURCE(IRQ_SOURCE), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_ACK(IRQ_ACK),
   .IRQ_RETURN(IRQ_RETURN));
